// ==== rtl/odrd_pkg.sv ====
// Constants, field layout and helpers for the output-disable request detector
package odrd_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Register map (byte addresses)
  localparam int ADDR_W = 5;
  localparam logic [4:0] ADDR_CTRL = 5'h00;
  localparam logic [4:0] ADDR_STATUS = 5'h04;
  localparam logic [4:0] ADDR_INT_STATUS = 5'h08;
  localparam logic [4:0] ADDR_INT_MASK = 5'h0C;

  ////////////////////////////////////////////////////////////////////////////////
  // Control register field positions and reset values
  localparam int CTRL_W = 16;
  localparam int FLD_W = 4;
  localparam int CTRL_MODE8_LSB = 0;
  localparam int CTRL_COUNT8_LSB = 4;
  localparam int CTRL_MODE10_LSB = 8;
  localparam int CTRL_COUNT10_LSB = 12;
  localparam logic [15:0] CTRL_RST = 16'h0000;
  localparam int NCHAN = 2;
  localparam int CH8 = 0;
  localparam int CH10 = 1;

  ////////////////////////////////////////////////////////////////////////////////
  // Detection mode encodings
  localparam logic [3:0] MODE_EDGE = 4'h0;
  localparam logic [3:0] MODE_DIV8 = 4'h1;
  localparam logic [3:0] MODE_DIV16 = 4'h2;
  localparam logic [3:0] MODE_DIV128 = 4'h3;
  localparam logic [3:0] MODE_PCLK = 4'h4;
  localparam logic [3:0] MODE_DIV2 = 4'h5;
  localparam logic [3:0] MODE_DIV4 = 4'h6;

  ////////////////////////////////////////////////////////////////////////////////
  // Prescaler masks: a sample is taken when the masked prescaler is zero
  localparam int PRE_W = 7;
  localparam logic [6:0] MASK_PCLK = 7'h00;
  localparam logic [6:0] MASK_DIV2 = 7'h01;
  localparam logic [6:0] MASK_DIV4 = 7'h03;
  localparam logic [6:0] MASK_DIV8 = 7'h07;
  localparam logic [6:0] MASK_DIV16 = 7'h0F;
  localparam logic [6:0] MASK_DIV128 = 7'h7F;

  // Sampled detection modes
  function automatic logic odrd_is_sampled(input logic [3:0] m);
    return (m >= MODE_DIV8) && (m <= MODE_DIV4);
  endfunction : odrd_is_sampled

  // Prescaler mask for a mode
  function automatic logic [6:0] odrd_div_mask(input logic [3:0] m);
    logic [6:0] r;
    r = MASK_PCLK;
    case (m)
      MODE_DIV8: r = MASK_DIV8;
      MODE_DIV16: r = MASK_DIV16;
      MODE_DIV128: r = MASK_DIV128;
      MODE_DIV2: r = MASK_DIV2;
      MODE_DIV4: r = MASK_DIV4;
      default: r = MASK_PCLK;
    endcase
    return r;
  endfunction : odrd_div_mask

endpackage : odrd_pkg

// ==== rtl/odrd_chan_if.sv ====
// Carrier between the register block and one request detector channel
`timescale 1ns/1ns
interface odrd_chan_if;
  logic [3:0] mode;
  logic [3:0] count;
  logic pin_n;
  logic det;
  logic pin_high;
  modport ctl (output mode, output count, output pin_n, input det, input pin_high);
  modport det_side (input mode, input count, input pin_n, output det, output pin_high);
endinterface : odrd_chan_if

// ==== rtl/odrd_chan.sv ====
// One request input detector: synchroniser, prescaler, edge and low-run detection
`timescale 1ns/1ns
module odrd_chan (
  input wire logic mclk_i,
  input wire logic rst_i,
  odrd_chan_if.det_side ch
);

  typedef struct packed {
    logic sync1;
    logic sync2;
    logic prev;
    logic [6:0] pre;
    logic [4:0] run;
    logic det;
    logic high;
  } odrd_chan_type;

  localparam odrd_chan_type CHAN_RST = '{sync1: 1'b1, sync2: 1'b1, prev: 1'b1,
    pre: 7'h00, run: 5'h00, det: 1'b0, high: 1'b1};

  odrd_chan_type s_r;
  odrd_chan_type s_nxt;
  logic tick;
  logic [4:0] thr;
  logic [4:0] run_inc;

  ////////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    s_nxt = s_r;
    s_nxt.sync1 = ch.pin_n;
    s_nxt.sync2 = s_r.sync1;
    s_nxt.prev = s_r.sync2;
    s_nxt.pre = s_r.pre + 7'h01;
    s_nxt.high = s_r.sync2;
    s_nxt.det = 1'b0;
    tick = (s_r.pre & odrd_pkg::odrd_div_mask(ch.mode)) == odrd_pkg::MASK_PCLK;
    thr = {1'b0, ch.count} + 5'h01;
    run_inc = s_r.run + 5'h01;
    if (ch.mode == odrd_pkg::MODE_EDGE) begin
      s_nxt.run = 5'h00;
      s_nxt.det = s_r.prev & ~s_r.sync2;
    end else if (odrd_pkg::odrd_is_sampled(ch.mode)) begin
      if (tick) begin
        if (s_r.sync2) begin
          s_nxt.run = 5'h00;
        end else if (run_inc >= thr) begin
          s_nxt.run = thr;
          s_nxt.det = 1'b1;
        end else begin
          s_nxt.run = run_inc;
        end
      end
    end else begin
      s_nxt.run = 5'h00;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      s_r <= CHAN_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign ch.det = s_r.det;
  assign ch.pin_high = s_r.high;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  AST_EDGE_DET: assert property (ch.mode == odrd_pkg::MODE_EDGE && s_r.prev && !s_r.sync2
    |=> s_r.det) else $error("falling edge not detected");
  AST_DIV8: assert property (s_r.det && $past(ch.mode) == odrd_pkg::MODE_DIV8
    |-> $past(s_r.pre[2:0]) == 3'h0) else $error("div8 detect off tick");
  AST_DIV16: assert property (s_r.det && $past(ch.mode) == odrd_pkg::MODE_DIV16
    |-> $past(s_r.pre[3:0]) == 4'h0) else $error("div16 detect off tick");
  AST_DIV128: assert property (s_r.det && $past(ch.mode) == odrd_pkg::MODE_DIV128
    |-> $past(s_r.pre) == 7'h00) else $error("div128 detect off tick");
  AST_PCLK: assert property (ch.mode == odrd_pkg::MODE_PCLK && ch.count == 4'h0
    && !s_r.sync2 ##1 ch.mode == odrd_pkg::MODE_PCLK |-> s_r.det)
    else $error("pclk sample missed");
  AST_DIV2: assert property (s_r.det && $past(ch.mode) == odrd_pkg::MODE_DIV2
    |-> $past(s_r.pre[0]) == 1'b0) else $error("div2 detect off tick");
  AST_DIV4: assert property (s_r.det && $past(ch.mode) == odrd_pkg::MODE_DIV4
    |-> $past(s_r.pre[1:0]) == 2'h0) else $error("div4 detect off tick");
  AST_RUN_RESTART: assert property (odrd_pkg::odrd_is_sampled(ch.mode) && tick
    && s_r.sync2 |=> s_r.run == 5'h00 && !s_r.det) else $error("run not restarted on high");
  AST_COUNT: assert property (s_r.det && odrd_pkg::odrd_is_sampled($past(ch.mode))
    |-> $past(s_r.run) + 5'h01 >= {1'b0, $past(ch.count)} + 5'h01)
    else $error("detect before count reached");

endmodule : odrd_chan

// ==== rtl/odrd_top.sv ====
// Output-disable request detector: Avalon-MM registers, request flags, interrupt
`timescale 1ns/1ns
module odrd_top (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic [4:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic request8_in_n_i,
  input wire logic request10_in_n_i,
  output logic request8_flag_o,
  output logic request10_flag_o,
  output logic irq_o
);

  typedef struct packed {
    logic [15:0] ctrl;
    logic [1:0] flag;
    logic [1:0] seen;
    logic [1:0] ist;
    logic [1:0] imask;
    logic stall;
    logic [31:0] rdata;
    logic irq;
  } odrd_top_type;

  localparam odrd_top_type TOP_RST = '{ctrl: odrd_pkg::CTRL_RST, flag: 2'h0, seen: 2'h0,
    ist: 2'h0, imask: 2'h0, stall: 1'b1, rdata: 32'h0000_0000, irq: 1'b0};

  odrd_top_type s_r;
  odrd_top_type s_nxt;
  logic req;
  logic start;
  logic acc;
  logic wr_status;
  logic [1:0] det;
  logic [1:0] high;
  logic [1:0] clr;
  logic [1:0] w1c;
  logic [3:0] mode8;
  logic [3:0] mode10;

  odrd_chan_if ch8 ();
  odrd_chan_if ch10 ();

  ////////////////////////////////////////////////////////////////////////////////
  // Detector channels
  assign mode8 = s_r.ctrl[odrd_pkg::CTRL_MODE8_LSB +: odrd_pkg::FLD_W];
  assign mode10 = s_r.ctrl[odrd_pkg::CTRL_MODE10_LSB +: odrd_pkg::FLD_W];
  assign ch8.mode = mode8;
  assign ch8.count = s_r.ctrl[odrd_pkg::CTRL_COUNT8_LSB +: odrd_pkg::FLD_W];
  assign ch8.pin_n = request8_in_n_i;
  assign ch10.mode = mode10;
  assign ch10.count = s_r.ctrl[odrd_pkg::CTRL_COUNT10_LSB +: odrd_pkg::FLD_W];
  assign ch10.pin_n = request10_in_n_i;

  odrd_chan u_ch8 (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .ch(ch8)
  );

  odrd_chan u_ch10 (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .ch(ch10)
  );

  assign det = {ch10.det, ch8.det};
  assign high = {ch10.pin_high, ch8.pin_high};

  ////////////////////////////////////////////////////////////////////////////////
  // Bus handshake: one wait cycle, then the access completes
  assign req = avs_read_i | avs_write_i;
  assign start = req & s_r.stall;
  assign acc = req & ~s_r.stall;
  assign wr_status = acc & avs_write_i & (avs_address_i == odrd_pkg::ADDR_STATUS)
    & avs_byteenable_i[0];

  always_comb begin
    s_nxt = s_r;
    s_nxt.stall = ~start;
    // Read data is captured while the slave stalls
    if (start) begin
      if (avs_address_i == odrd_pkg::ADDR_CTRL) begin
        s_nxt.rdata = {16'h0000, s_r.ctrl};
      end else if (avs_address_i == odrd_pkg::ADDR_STATUS) begin
        s_nxt.rdata = {30'h0000_0000, s_r.flag};
      end else if (avs_address_i == odrd_pkg::ADDR_INT_STATUS) begin
        s_nxt.rdata = {30'h0000_0000, s_r.ist};
      end else if (avs_address_i == odrd_pkg::ADDR_INT_MASK) begin
        s_nxt.rdata = {30'h0000_0000, s_r.imask};
      end else begin
        s_nxt.rdata = 32'h0000_0000;
      end
    end
    // Control register write, per byte lane
    if (acc && avs_write_i && avs_address_i == odrd_pkg::ADDR_CTRL) begin
      if (avs_byteenable_i[0]) begin
        s_nxt.ctrl[7:0] = avs_writedata_i[7:0];
      end
      if (avs_byteenable_i[1]) begin
        s_nxt.ctrl[15:8] = avs_writedata_i[15:8];
      end
    end
    if (acc && avs_write_i && avs_address_i == odrd_pkg::ADDR_INT_MASK
        && avs_byteenable_i[0]) begin
      s_nxt.imask = avs_writedata_i[1:0];
    end
    // Read-as-one tracking for the flag clear
    if (acc && avs_read_i && avs_address_i == odrd_pkg::ADDR_STATUS) begin
      s_nxt.seen = s_r.rdata[1:0] & s_r.flag;
    end else if (wr_status) begin
      s_nxt.seen = 2'h0;
    end
    // Flags: a new detection wins over a clear in the same cycle
    clr[0] = wr_status & ~avs_writedata_i[0] & s_r.seen[0]
      & (~odrd_pkg::odrd_is_sampled(mode8) | high[0]);
    clr[1] = wr_status & ~avs_writedata_i[1] & s_r.seen[1]
      & (~odrd_pkg::odrd_is_sampled(mode10) | high[1]);
    s_nxt.flag = det | (s_r.flag & ~clr);
    // Interrupt status, write one to clear
    w1c = 2'h0;
    if (acc && avs_write_i && avs_address_i == odrd_pkg::ADDR_INT_STATUS
        && avs_byteenable_i[0]) begin
      w1c = avs_writedata_i[1:0];
    end
    s_nxt.ist = det | (s_r.ist & ~w1c);
    s_nxt.irq = |(s_nxt.ist & s_nxt.imask);
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      s_r <= TOP_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign avs_readdata_o = s_r.rdata;
  assign avs_waitrequest_o = s_r.stall;
  assign request8_flag_o = s_r.flag[odrd_pkg::CH8];
  assign request10_flag_o = s_r.flag[odrd_pkg::CH10];
  assign irq_o = s_r.irq;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  AST_FLAG8_SET: assert property (ch8.det |=> request8_flag_o)
    else $error("request-8 flag not set on detect");

  AST_FLAG10_SET: assert property (ch10.det |=> request10_flag_o)
    else $error("request-10 flag not set on detect");

  AST_SET_WINS8: assert property (ch8.det && clr[0] |=> request8_flag_o)
    else $error("request-8 clear beat a detection");

  AST_SET_WINS10: assert property (ch10.det && clr[1] |=> request10_flag_o)
    else $error("request-10 clear beat a detection");

  AST_FLAG8_CLEAR: assert property ($fell(request8_flag_o) |-> $past(wr_status)
    && !$past(avs_writedata_i[0]) && $past(s_r.seen[0]))
    else $error("request-8 flag cleared without read-one then write-zero");

  AST_FLAG10_CLEAR: assert property ($fell(request10_flag_o) |-> $past(wr_status)
    && !$past(avs_writedata_i[1]) && $past(s_r.seen[1]))
    else $error("request-10 flag cleared without read-one then write-zero");

  AST_WRITE_ONE8: assert property (wr_status && avs_writedata_i[0] && request8_flag_o
    |=> request8_flag_o) else $error("request-8 flag cleared by writing one");

  AST_WRITE_ONE10: assert property (wr_status && avs_writedata_i[1] && request10_flag_o
    |=> request10_flag_o) else $error("request-10 flag cleared by writing one");

  AST_UNREAD8: assert property (wr_status && !s_r.seen[0] && request8_flag_o
    |=> request8_flag_o) else $error("request-8 flag cleared without a read of one");

  AST_UNREAD10: assert property (wr_status && !s_r.seen[1] && request10_flag_o
    |=> request10_flag_o) else $error("request-10 flag cleared without a read of one");

  AST_CLEAR8_DONE: assert property (wr_status && !avs_writedata_i[0] && s_r.seen[0]
    && high[0] && !ch8.det |=> !request8_flag_o) else $error("request-8 flag not cleared");

  AST_CLEAR10_DONE: assert property (wr_status && !avs_writedata_i[1] && s_r.seen[1]
    && high[1] && !ch10.det |=> !request10_flag_o) else $error("request-10 flag not cleared");

  AST_SEEN_RESET: assert property (wr_status |=> s_r.seen == 2'h0)
    else $error("status write kept the read-as-one memory");

  AST_CLEAR_HIGH: assert property ($fell(request8_flag_o)
    && odrd_pkg::odrd_is_sampled($past(mode8)) |-> $past(high[0]))
    else $error("flag cleared while input low in sampled mode");

  AST_CLEAR_HIGH10: assert property ($fell(request10_flag_o)
    && odrd_pkg::odrd_is_sampled($past(mode10)) |-> $past(high[1]))
    else $error("request-10 flag cleared while input low in sampled mode");

  ////////////////////////////////////////////////////////////////////////////////
  // Control and mask registers
  AST_CTRL_WR: assert property (acc && avs_write_i && avs_address_i == odrd_pkg::ADDR_CTRL
    && avs_byteenable_i[1] |=> mode10 == $past(avs_writedata_i[11:8])
    && ch10.count == $past(avs_writedata_i[15:12]))
    else $error("request-10 fields not written");

  AST_CTRL8_WR: assert property (acc && avs_write_i && avs_address_i == odrd_pkg::ADDR_CTRL
    && avs_byteenable_i[0] |=> ch8.count == $past(avs_writedata_i[7:4])
    && mode8 == $past(avs_writedata_i[3:0]))
    else $error("request-8 fields not written");

  AST_KEEP8: assert property (acc && avs_write_i && avs_address_i == odrd_pkg::ADDR_CTRL
    && !avs_byteenable_i[0] |=> $stable(mode8) && $stable(ch8.count))
    else $error("request-8 fields changed without their byte lane");

  AST_KEEP10: assert property (acc && avs_write_i && avs_address_i == odrd_pkg::ADDR_CTRL
    && !avs_byteenable_i[1] |=> $stable(mode10) && $stable(ch10.count))
    else $error("request-10 fields changed without their byte lane");

  AST_CTRL_HOLD: assert property (!(acc && avs_write_i) |=> $stable(s_r.ctrl))
    else $error("control register changed without a write");

  AST_MASK_WR: assert property (acc && avs_write_i && avs_address_i == odrd_pkg::ADDR_INT_MASK
    && avs_byteenable_i[0] |=> s_r.imask == $past(avs_writedata_i[1:0]))
    else $error("interrupt mask not written");

  AST_MASK_HOLD: assert property (!(acc && avs_write_i && avs_byteenable_i[0]
    && avs_address_i == odrd_pkg::ADDR_INT_MASK) |=> $stable(s_r.imask))
    else $error("interrupt mask changed without a write");

  ////////////////////////////////////////////////////////////////////////////////
  // Bus handshake and read data
  AST_WAIT_ONE: assert property (req && avs_waitrequest_o |=> !avs_waitrequest_o ##1
    avs_waitrequest_o) else $error("bus answer not after one wait cycle");

  AST_IDLE_WAIT: assert property (!req |=> avs_waitrequest_o)
    else $error("waitrequest low without a request");

  AST_WAIT_BACK: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("waitrequest low for more than one cycle");

  AST_RD_CTRL: assert property (start && avs_address_i == odrd_pkg::ADDR_CTRL
    |=> avs_readdata_o == {16'h0000, $past(s_r.ctrl)}) else $error("control readback wrong");

  AST_RD_STATUS: assert property (start && avs_address_i == odrd_pkg::ADDR_STATUS
    |=> avs_readdata_o == {30'h0000_0000, $past(s_r.flag)}) else $error("status readback wrong");

  AST_RD_IST: assert property (start && avs_address_i == odrd_pkg::ADDR_INT_STATUS
    |=> avs_readdata_o == {30'h0000_0000, $past(s_r.ist)}) else $error("event readback wrong");

  AST_RD_MASK: assert property (start && avs_address_i == odrd_pkg::ADDR_INT_MASK
    |=> avs_readdata_o == {30'h0000_0000, $past(s_r.imask)}) else $error("mask readback wrong");

  AST_RD_UNMAPPED: assert property (start && avs_address_i != odrd_pkg::ADDR_CTRL
    && avs_address_i != odrd_pkg::ADDR_STATUS && avs_address_i != odrd_pkg::ADDR_INT_STATUS
    && avs_address_i != odrd_pkg::ADDR_INT_MASK |=> avs_readdata_o == 32'h0000_0000)
    else $error("unmapped read not zero");

  AST_RD_HOLD: assert property (!start |=> $stable(avs_readdata_o))
    else $error("read data changed without a request");

  ////////////////////////////////////////////////////////////////////////////////
  // Interrupt status and request
  AST_IST8_SET: assert property (ch8.det |=> s_r.ist[0])
    else $error("request-8 event not recorded");

  AST_IST10_SET: assert property (ch10.det |=> s_r.ist[1])
    else $error("request-10 event not recorded");

  AST_IST_W1C: assert property (acc && avs_write_i && avs_address_i == odrd_pkg::ADDR_INT_STATUS
    && avs_byteenable_i[0] && avs_writedata_i[0] && !ch8.det |=> !s_r.ist[0])
    else $error("request-8 event bit not cleared by a one");

  AST_IST_W1C10: assert property (acc && avs_write_i && avs_byteenable_i[0]
    && avs_address_i == odrd_pkg::ADDR_INT_STATUS && avs_writedata_i[1] && !ch10.det
    |=> !s_r.ist[1]) else $error("request-10 event bit not cleared by a one");

  AST_IRQ: assert property (ch10.det && s_r.imask[1] ##1 !(acc && avs_write_i) |=> irq_o)
    else $error("unmasked event did not raise interrupt");

  AST_IRQ_LEVEL: assert property (irq_o == |(s_r.ist & s_r.imask))
    else $error("interrupt output does not follow status and mask");

endmodule : odrd_top

// ==== tb/odrd_src_model.sv ====
// Request source model: drives the two active-low request inputs
`timescale 1ns/1ns
module odrd_src_model (
  input wire logic mclk_i,
  output logic request8_in_n_o,
  output logic request10_in_n_o
);
  initial begin
    request8_in_n_o = 1'b1;
    request10_in_n_o = 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Set one request line just after the next rising edge
  task automatic level(input int ch, input logic v);
    @(posedge mclk_i);
    if (ch == 0) begin
      request8_in_n_o <= v;
    end else begin
      request10_in_n_o <= v;
    end
  endtask : level

  // Low run of len cycles, then back high so a clearing write can act
  task automatic low_run(input int ch, input int len);
    level(ch, 1'b0);
    repeat (len) @(posedge mclk_i);
    if (ch == 0) begin
      request8_in_n_o <= 1'b1;
    end else begin
      request10_in_n_o <= 1'b1;
    end
  endtask : low_run
endmodule : odrd_src_model

// ==== tb/output_disable_request_detect_tb.sv ====
// Self-checking bench for the request detector with a behavioural flag model
`timescale 1ns/1ns
module output_disable_request_detect_tb;
  logic mclk_i, rst_i, avs_read_i, avs_write_i, avs_waitrequest_o, irq_o;
  logic request8_in_n_i, request10_in_n_i, request8_flag_o, request10_flag_o;
  logic [4:0] avs_address_i;
  logic [31:0] avs_writedata_i, avs_readdata_o, q;
  logic [3:0] avs_byteenable_i;
  logic [1:0] ef, ei, mask;
  int n_mismatch, checks, seed, n, d, m, ch;

  initial begin
    mclk_i = 1'b0;
    forever #5 mclk_i = ~mclk_i;
  end

  odrd_top dut (.mclk_i(mclk_i), .rst_i(rst_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .request8_in_n_i(request8_in_n_i),
    .request10_in_n_i(request10_in_n_i), .request8_flag_o(request8_flag_o),
    .request10_flag_o(request10_flag_o), .irq_o(irq_o));

  odrd_src_model src (.mclk_i(mclk_i), .request8_in_n_o(request8_in_n_i),
    .request10_in_n_o(request10_in_n_i));

  ////////////////////////////////////////////////////////////////////////////////
  // Helpers
  task print_verdict;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : print_verdict

  task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task bus(input logic wr, input logic [4:0] a, input logic [31:0] wd, input logic [3:0] be);
    int i;
    @(posedge mclk_i);
    avs_address_i <= a;
    avs_writedata_i <= wd;
    avs_byteenable_i <= be;
    avs_read_i <= !wr;
    avs_write_i <= wr;
    for (i = 0; i < 20; i++) begin
      @(posedge mclk_i);
      if (avs_waitrequest_o === 1'b0) break;
    end
    q = avs_readdata_o;
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
    if (i == 20) begin
      n_mismatch++;
      print_verdict();
    end
  endtask : bus

  // Sample period in clocks for each listed mode, 0 for edge detection
  function automatic int div_of(input int md);
    case (md)
      1: return 8;
      2: return 16;
      3: return 128;
      4: return 1;
      5: return 2;
      6: return 4;
      default: return 0;
    endcase
  endfunction : div_of

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    seed = 32'hca2a_b2e2;
    rst_i = 1'b1;
    avs_read_i = 1'b0;
    avs_write_i = 1'b0;
    avs_address_i = 5'h00;
    avs_writedata_i = 32'h0000_0000;
    avs_byteenable_i = 4'h0;
    n_mismatch = 0;
    checks = 0;
    ef = 2'b00;
    ei = 2'b00;
    repeat (6) @(posedge mclk_i);
    rst_i <= 1'b0;
    bus(1'b0, odrd_pkg::ADDR_CTRL, 32'h0000_0000, 4'hF);
    chk("ctrl_reset", q, 32'h0000_0000);
    bus(1'b1, odrd_pkg::ADDR_CTRL, 32'hFFFF_FF36, 4'h1);
    bus(1'b0, odrd_pkg::ADDR_CTRL, 32'h0000_0000, 4'hF);
    chk("ctrl_lane", q, 32'h0000_0036);
    bus(1'b0, 5'h14, 32'h0000_0000, 4'hF);
    chk("unmapped", q, 32'h0000_0000);
    for (ch = 0; ch < 2; ch++) begin
      for (m = 0; m < 7; m++) begin
        n = 2 + ($unsigned($random(seed)) % 4);
        d = div_of(m);
        mask = 2'($random(seed));
        bus(1'b1, odrd_pkg::ADDR_INT_MASK, {30'h0, mask}, 4'hF);
        bus(1'b1, odrd_pkg::ADDR_CTRL, 32'((m | (n << 4)) << (8 * ch)), 4'h3);
        if (m != 0) begin
          src.low_run(ch, (n - 1) * d);
          repeat (d) @(posedge mclk_i);
          src.low_run(ch, (n - 1) * d);
          repeat (8) @(posedge mclk_i);
          bus(1'b0, odrd_pkg::ADDR_STATUS, 32'h0000_0000, 4'hF);
          chk("status_short_runs", q, {30'h0, ef});
          src.low_run(ch, (n + 2) * d);
        end else begin
          src.low_run(ch, 1);
        end
        repeat (8) @(posedge mclk_i);
        ef[ch] = 1'b1;
        ei[ch] = 1'b1;
        chk("flag_pin", {30'h0, request10_flag_o, request8_flag_o}, {30'h0, ef});
        bus(1'b1, odrd_pkg::ADDR_STATUS, 32'h0000_0000, 4'h1);
        bus(1'b0, odrd_pkg::ADDR_STATUS, 32'h0000_0000, 4'hF);
        chk("status_unread_clear", q, {30'h0, ef});
        if (m != 0) begin
          src.level(ch, 1'b0);
          repeat (4) @(posedge mclk_i);
          bus(1'b1, odrd_pkg::ADDR_STATUS, 32'h0000_0000, 4'h1);
          bus(1'b0, odrd_pkg::ADDR_STATUS, 32'h0000_0000, 4'hF);
          chk("status_held_low", q, {30'h0, ef});
          src.level(ch, 1'b1);
          repeat (8) @(posedge mclk_i);
          bus(1'b0, odrd_pkg::ADDR_STATUS, 32'h0000_0000, 4'hF);
        end
        bus(1'b1, odrd_pkg::ADDR_STATUS, 32'h0000_0000, 4'h1);
        ef[ch] = 1'b0;
        bus(1'b0, odrd_pkg::ADDR_STATUS, 32'h0000_0000, 4'hF);
        chk("status_cleared", q, {30'h0, ef});
        bus(1'b0, odrd_pkg::ADDR_INT_STATUS, 32'h0000_0000, 4'hF);
        chk("int_status", q, {30'h0, ei});
        chk("irq", {31'h0, irq_o}, {31'h0, |(ei & mask)});
        bus(1'b1, odrd_pkg::ADDR_INT_STATUS, 32'(1 << ch), 4'hF);
        ei[ch] = 1'b0;
        bus(1'b0, odrd_pkg::ADDR_INT_STATUS, 32'h0000_0000, 4'hF);
        chk("int_cleared", q, {30'h0, ei});
        $display("test channel %0d mode %0d count %0d done", ch, m, n);
      end
    end
    print_verdict();
  end
endmodule : output_disable_request_detect_tb
